// [hdl/pin_location_selector.sv]
// Register-controlled pin location selector with an AXI4-Lite slave.
// Operation
// R1 - Logic table 1 bit selects alternative pin.
// R2 - Logic table 0 bit selects alternative pin.
// R3 - Event output bits connect event channels.
// R4 - Two-wire bit moves its pins.
// R5 - Serial peripheral bit moves its pins.
// R6 - Serial port bit moves its pins.
// R7 - Timer A outputs 3-5 move only split.
// R8 - Timer A outputs 0-2 always move.
// R9 - Timer B second bit selects alternative pin.
// R10 - Timer B first bit selects alternative pin.
// R11 - All controls reset to zero.
// R12 - Routing follows register one cycle later.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pin_location_selector_map.svh"

module pin_location_selector #(
    parameter int ADDR_W    = 4,
    parameter int NUM_EVENT = 3,
    parameter int NUM_WAVE  = 6
) (
    input  wire logic                                aclk,
    input  wire logic                                aresetn,
    input  wire logic [ADDR_W-1:0]                   s_axi_awaddr,
    input  wire logic                                s_axi_awvalid,
    output logic                                     s_axi_awready,
    input  wire logic [31:0]                         s_axi_wdata,
    input  wire logic [3:0]                          s_axi_wstrb,
    input  wire logic                                s_axi_wvalid,
    output logic                                     s_axi_wready,
    output pin_location_selector_pkg::axi_resp_t     s_axi_bresp,
    output logic                                     s_axi_bvalid,
    input  wire logic                                s_axi_bready,
    input  wire logic [ADDR_W-1:0]                   s_axi_araddr,
    input  wire logic                                s_axi_arvalid,
    output logic                                     s_axi_arready,
    output logic [31:0]                              s_axi_rdata,
    output pin_location_selector_pkg::axi_resp_t     s_axi_rresp,
    output logic                                     s_axi_rvalid,
    input  wire logic                                s_axi_rready,
    input  wire logic                                timer_a_split_mode,
    input  wire logic [NUM_EVENT-1:0]                event_chan,
    output logic [NUM_EVENT-1:0]                     event_pin_out,
    output logic [NUM_EVENT-1:0]                     event_pin_oe,
    output pin_location_selector_pkg::route_sel_t    route_sel
);
    import pin_location_selector_pkg::*;

    // The register map and the route struct are laid out for these sizes.
    if (ADDR_W != 4) begin : g_addr_check
        $error("pin selector address width must be four");
    end
    if (NUM_EVENT != 3) begin : g_event_check
        $error("pin selector has exactly three event outputs");
    end
    if (NUM_WAVE != 6) begin : g_wave_check
        $error("pin selector has exactly six timer A outputs");
    end

    logic [7:0]  logic_event_q;
    logic [7:0]  comm_q;
    logic [7:0]  timer_a_q;
    logic [7:0]  timer_b_q;
    logic [3:0]  awaddr_q;
    logic        aw_held_q;
    logic [7:0]  wdata_q;
    logic        wstrb0_q;
    logic        w_held_q;
    logic        do_write;
    logic        wr_en;
    logic [7:0]  wr_index;
    logic        wr_hit;
    logic        rd_hit;
    logic [7:0]  rd_byte;
    logic [5:0]  wave_alt;
    axi_resp_t   bresp_q;
    axi_resp_t   rresp_q;
    logic [31:0] rdata_q;
    logic        bvalid_q;
    logic        rvalid_q;
    pin_pair_t   table1_q;
    pin_pair_t   table0_q;
    pin_pair_t   two_wire_q;
    pin_pair_t   periph_q;
    pin_pair_t   port_q;
    logic [11:0] wave_q;
    pin_pair_t   timer_b2_q;
    pin_pair_t   timer_b1_q;

    localparam pin_pair_t PAIR_RESET = pin_pair_t'(`PIN_PAIR_RESET);

    // Address and data may arrive in either order; each is latched alone.
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign do_write      = aw_held_q && w_held_q && !bvalid_q;
    // One read at a time: a new address waits for the last answer.
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            awaddr_q  <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            wdata_q  <= 8'h00;
            wstrb0_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata[7:0];
            wstrb0_q <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held_q <= 1'b0;
        end
    end

    assign wr_hit   = awaddr_q[1:0] == 2'h0 && awaddr_q[3:2] <= 2'h3;
    assign wr_index = {4'h0, awaddr_q} >> 2;
    // A refused write must leave every control untouched.
    // Only the low byte lane carries a control, so wstrb[0] gates it.
    assign wr_en    = do_write && wr_hit && wstrb0_q;

    // Reserved bits are masked so they always read back as zero.
    // R11 - Control A resets zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            logic_event_q <= `CTRL_RESET;
        end else if (wr_en && wr_index == `LOGIC_EVENT_PIN_CTRL_OFS) begin
            logic_event_q <= wdata_q & `LOGIC_EVENT_MASK;
        end
    end

    // R11 - Control B resets zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            comm_q <= `CTRL_RESET;
        end else if (wr_en && wr_index == `COMM_PIN_CTRL_OFS) begin
            comm_q <= wdata_q & `COMM_MASK;
        end
    end

    // R11 - Control C resets zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_a_q <= `CTRL_RESET;
        end else if (wr_en && wr_index == `TIMER_A_PIN_CTRL_OFS) begin
            timer_a_q <= wdata_q & `TIMER_A_MASK;
        end
    end

    // R11 - Control D resets zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_b_q <= `CTRL_RESET;
        end else if (wr_en && wr_index == `TIMER_B_PIN_CTRL_OFS) begin
            timer_b_q <= wdata_q & `TIMER_B_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Misaligned reads answer with an error and zero data.
    assign rd_hit = s_axi_araddr[1:0] == 2'h0;

    always_comb begin
        unique case ({4'h0, s_axi_araddr} >> 2)
            `LOGIC_EVENT_PIN_CTRL_OFS: rd_byte = logic_event_q;
            `COMM_PIN_CTRL_OFS:        rd_byte = comm_q;
            `TIMER_A_PIN_CTRL_OFS:     rd_byte = timer_a_q;
            `TIMER_B_PIN_CTRL_OFS:     rd_byte = timer_b_q;
            default:                   rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= (rd_hit && s_axi_araddr[3:2] <= 2'h3)
                        ? {24'h000000, rd_byte} : 32'h00000000;
            rresp_q  <= (rd_hit && s_axi_araddr[3:2] <= 2'h3)
                        ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // R7 - Upper waves split-only.
    assign wave_alt[5:3] = timer_a_split_mode
        ? timer_a_q[`TIMER_A_HI_MSB:`TIMER_A_HI_LSB] : 3'h0;
    // R8 - Lower waves always.
    assign wave_alt[2:0] = timer_a_q[`TIMER_A_LO_MSB:`TIMER_A_LO_LSB];

    // Each function drives exactly one of its two pins at any time.
    function automatic pin_pair_t pair_of(input logic use_alt);
        pin_pair_t p;
        p.dflt = !use_alt;
        p.alt  = use_alt;
        return p;
    endfunction

    // Registered selects keep the pin enables free of decode glitches,
    // at the price of one cycle of lag behind a register write.
    // R1 - Logic table 1.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            table1_q <= PAIR_RESET;
        end else begin
            table1_q <= pair_of(logic_event_q[`LOGIC_TABLE1_BIT]);
        end
    end

    // R2 - Logic table 0.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            table0_q <= PAIR_RESET;
        end else begin
            table0_q <= pair_of(logic_event_q[`LOGIC_TABLE0_BIT]);
        end
    end

    // R4 - Two-wire pins.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            two_wire_q <= PAIR_RESET;
        end else begin
            two_wire_q <= pair_of(comm_q[`TWO_WIRE_BIT]);
        end
    end

    // R5 - Serial peripheral pins.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            periph_q <= PAIR_RESET;
        end else begin
            periph_q <= pair_of(comm_q[`SERIAL_PERIPH_BIT]);
        end
    end

    // R6 - Serial port pins.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_q <= PAIR_RESET;
        end else begin
            port_q <= pair_of(comm_q[`SERIAL_PORT_BIT]);
        end
    end

    // R9 - Timer B second.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_b2_q <= PAIR_RESET;
        end else begin
            timer_b2_q <= pair_of(timer_b_q[`TIMER_B_SECOND_BIT]);
        end
    end

    // R10 - Timer B first.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_b1_q <= PAIR_RESET;
        end else begin
            timer_b1_q <= pair_of(timer_b_q[`TIMER_B_FIRST_BIT]);
        end
    end

    // Outputs 3-5 see their bit only in split mode, through wave_alt.
    // R12 - One pair per wave.
    for (genvar w = 0; w < NUM_WAVE; w++) begin : g_wave
        pin_pair_t pair_q;
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                pair_q <= PAIR_RESET;
            end else begin
                pair_q <= pair_of(wave_alt[w]);
            end
        end
        assign wave_q[2*w+1:2*w] = pair_q;
    end

    // R12 - Registered routing update.
    assign route_sel = route_sel_t'({table1_q, table0_q, two_wire_q,
        periph_q, port_q, wave_q, timer_b2_q, timer_b1_q});

    // R3 - Event outputs gated.
    for (genvar e = 0; e < NUM_EVENT; e++) begin : g_event
        logic out_q;
        logic oe_q;
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                out_q <= 1'b0;
                oe_q  <= 1'b0;
            end else begin
                // A disabled channel is held low as well as undriven.
                oe_q  <= logic_event_q[`EVENT_OUT0_BIT + e];
                out_q <= event_chan[e] & logic_event_q[`EVENT_OUT0_BIT + e];
            end
        end
        assign event_pin_out[e] = out_q;
        assign event_pin_oe[e]  = oe_q;
    end

endmodule

// [hdl/pin_location_selector_map.svh]
// Register offsets, field positions and reset values of the pin selector.
`ifndef PIN_LOCATION_SELECTOR_MAP_SVH
`define PIN_LOCATION_SELECTOR_MAP_SVH

`define LOGIC_EVENT_PIN_CTRL_OFS 8'h00
`define COMM_PIN_CTRL_OFS        8'h01
`define TIMER_A_PIN_CTRL_OFS     8'h02
`define TIMER_B_PIN_CTRL_OFS     8'h03
`define CTRL_RESET               8'h00
`define PIN_PAIR_RESET           2'h2

`define LOGIC_TABLE1_BIT 5
`define LOGIC_TABLE0_BIT 4
`define EVENT_OUT2_BIT   2
`define EVENT_OUT0_BIT   0
`define TWO_WIRE_BIT     4
`define SERIAL_PERIPH_BIT 2
`define SERIAL_PORT_BIT  0
`define TIMER_A_HI_MSB   5
`define TIMER_A_HI_LSB   3
`define TIMER_A_LO_MSB   2
`define TIMER_A_LO_LSB   0
`define TIMER_B_SECOND_BIT 1
`define TIMER_B_FIRST_BIT  0

`define LOGIC_EVENT_MASK 8'h37
`define COMM_MASK        8'h15
`define TIMER_A_MASK     8'h3F
`define TIMER_B_MASK     8'h03

`endif

// [hdl/pin_location_selector_pkg.sv]
// Types shared by the pin location selector.
package pin_location_selector_pkg;

    typedef enum logic [1:0] {
        RESP_OKAY   = 2'b00,
        RESP_SLVERR = 2'b10
    } axi_resp_t;

    // One routed signal pair: default and alternative pin positions.
    typedef struct packed {
        logic dflt;
        logic alt;
    } pin_pair_t;

    // Output enables for the default and alternative pin of each function.
    typedef struct packed {
        pin_pair_t       logic_table1;
        pin_pair_t       logic_table0;
        pin_pair_t       two_wire;
        pin_pair_t       serial_periph;
        pin_pair_t       serial_port;
        pin_pair_t [5:0] timer_a_wave;
        pin_pair_t       timer_b_second;
        pin_pair_t       timer_b_first;
    } route_sel_t;

endpackage

// [tb/pin_location_selector_assertions.sv]
// Port assertions for the pin location selector.
`timescale 1ns/1ps
module pin_location_selector_assertions (
    input wire logic                                 aclk,
    input wire logic                                 aresetn,
    input wire logic                                 s_axi_arvalid,
    input wire logic                                 s_axi_arready,
    input wire logic                                 s_axi_rvalid,
    input wire logic                                 s_axi_rready,
    input wire logic [31:0]                          s_axi_rdata,
    input wire logic                                 s_axi_bvalid,
    input wire logic                                 s_axi_bready,
    input wire pin_location_selector_pkg::axi_resp_t s_axi_bresp,
    input wire logic                                 timer_a_split_mode,
    input wire logic [2:0]                           event_chan,
    input wire logic [2:0]                           event_pin_out,
    input wire logic [2:0]                           event_pin_oe,
    input wire pin_location_selector_pkg::route_sel_t route_sel
);
    import pin_location_selector_pkg::*;
    // Flat copy so pair masks can be applied in one step.
    logic [25:0] rs_w;
    assign rs_w = route_sel;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_pair_onehot: assert property (
        ((rs_w ^ (rs_w >> 1)) & 26'h1555555) == 26'h1555555)
        else $error("pin pair enables not exclusive");
    chk_reset_dflt: assert property (disable iff (1'b0)
        !aresetn |=> rs_w == 26'h2AAAAAA && event_pin_oe == 3'h0
        && event_pin_out == 3'h0)
        else $error("routing not at default after reset");
    chk_event_gate: assert property (
        event_pin_out == ($past(event_chan) & event_pin_oe))
        else $error("event pin not gated by its enable");
    chk_split_gate: assert property (
        (!timer_a_split_mode)[*2] |=> (rs_w[15:10] & 6'h15) == 6'h00)
        else $error("upper timer outputs moved outside split mode");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_ar_refused: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
    chk_b_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    chk_r_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
endmodule
bind pin_location_selector pin_location_selector_assertions u_chk (.aclk,
    .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .timer_a_split_mode, .event_chan, .event_pin_out, .event_pin_oe,
    .route_sel);

// [tb/testbench.sv]
// Self-checking bench of the pin location selector.
`timescale 1ns/1ps
`include "pin_location_selector_map.svh"
module testbench;
    import pin_location_selector_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, split = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, rd, seed = 32'h63;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [2:0] chan = 3'h0, ev_out, ev_oe;
    axi_resp_t bresp, rresp, rs;
    route_sel_t route;
    logic [7:0] c [4] = '{default: 8'h00};
    int num_errors = 0, checked = 0;
    localparam logic [7:0] MSK [4] = '{`LOGIC_EVENT_MASK, `COMM_MASK,
        `TIMER_A_MASK, `TIMER_B_MASK};
    pin_location_selector u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .timer_a_split_mode(split),
        .event_chan(chan), .event_pin_out(ev_out), .event_pin_oe(ev_oe),
        .route_sel(route));
    always #50 aclk = ~aclk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic route_sel_t er();
        route_sel_t r;
        logic a;
        r.logic_table1 = {~c[0][5], c[0][5]};
        r.logic_table0 = {~c[0][4], c[0][4]};
        r.two_wire = {~c[1][4], c[1][4]};
        r.serial_periph = {~c[1][2], c[1][2]};
        r.serial_port = {~c[1][0], c[1][0]};
        for (int i = 0; i < 6; i++) begin
            a = c[2][i] & (i < 3 || split);
            r.timer_a_wave[i] = {~a, a};
        end
        r.timer_b_second = {~c[3][1], c[3][1]};
        r.timer_b_first = {~c[3][0], c[3][0]};
        return r;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Ready is sampled at the falling edge so the decision is race free.
    task automatic acc(input logic w, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int n;
        logic ta, tw, tr;
        n = 0;
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= w;
        wvalid <= w;
        arvalid <= !w;
        do begin
            @(negedge aclk);
            ta = w ? awready : arready;
            tw = wready;
            tr = w ? bvalid & bready : rvalid & rready;
            rd = rdata;
            rs = w ? bresp : rresp;
            @(posedge aclk);
            n++;
            if (ta) begin
                awvalid <= 1'b0;
                arvalid <= 1'b0;
            end
            if (tw) begin
                wvalid <= 1'b0;
            end
            if (n == 3) begin
                bready <= w;
                rready <= !w;
            end
        end while (!tr && n < 60);
        bready <= 1'b0;
        rready <= 1'b0;
        if (!tr) num_errors++;
    endtask
    task automatic put(input int k, input logic [31:0] v);
        acc(1'b1, 4'(k * 4), v, 4'hF);
        c[k] = v[7:0] & MSK[k];
        chk(rs, RESP_OKAY);
    endtask
    task automatic look();
        @(negedge aclk);
        chk(route, er());
        chk(ev_out, chan & c[0][2:0]);
        chk(ev_oe, c[0][2:0]);
        @(posedge aclk);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #2000000;
        num_errors++;
        test_done();
    end
    initial begin
        logic [31:0] v;
        int k;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        look();
        for (k = 0; k < 4; k++) begin
            acc(1'b0, 4'(k * 4), 32'h0, 4'h0);
            chk(rd, 32'h0);
        end
        $display("reset test done");
        chan <= 3'h5;
        for (k = 0; k < 4; k++) put(k, 32'hFF);
        look();
        split <= 1'b1;
        repeat (3) @(posedge aclk);
        look();
        $display("all ones test done");
        for (int t = 0; t < 40; t++) begin
            v = rnd();
            split <= v[8];
            chan <= v[11:9];
            k = int'(v[13:12]);
            put(k, v);
            acc(1'b0, 4'(k * 4), 32'h0, 4'h0);
            chk(rd, {24'h0, c[k]});
            chk(rs, RESP_OKAY);
            look();
        end
        $display("random test done");
        acc(1'b1, 4'h1, 32'hFF, 4'hF);
        chk(rs, RESP_SLVERR);
        acc(1'b1, 4'h4, 32'hFF, 4'h0);
        chk(rs, RESP_OKAY);
        acc(1'b0, 4'h1, 32'h0, 4'h0);
        chk(rd, 32'h0);
        chk(rs, RESP_SLVERR);
        acc(1'b0, 4'h4, 32'h0, 4'h0);
        chk(rd, {24'h0, c[1]});
        look();
        $display("refusal test done");
        aresetn <= 1'b0;
        c = '{default: 8'h00};
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        look();
        acc(1'b0, 4'h8, 32'h0, 4'h0);
        chk(rd, 32'h0);
        $display("second reset test done");
        test_done();
    end
endmodule
